// *** hw/mrx_pkg.sv ***
// package of constants and types for the move and return instruction executor
//------------------------------------------------------------
// Functional notes
// - store accumulator to direct file, one cycle
// - store accumulator to extended register, one cycle
// - load accumulator from extended register, 20h up
// - interrupt return pops stack into program counter
// - interrupt return sets global enable, two cycles
// - literal return loads accumulator, pops, two cycles
//------------------------------------------------------------
package mrx_pkg;
	// opcode geometry
	localparam int OP_W = 14;
	localparam int DATA_W = 8;
	// store direct: 00 0000 1fff ffff
	localparam logic [6:0] OPC_STORE_DIRECT = 7'h01;
	localparam int OPC_STORE_DIRECT_POS = 7;
	// extended store / load / literal return: upper six bits
	localparam logic [5:0] OPC_STORE_EXT = 6'h1E;
	localparam logic [5:0] OPC_LOAD_EXT = 6'h1F;
	localparam logic [5:0] OPC_RET_LIT = 6'h18;
	localparam int OPC_HI_POS = 8;
	// whole-word interrupt return
	localparam logic [13:0] OPC_IRQ_RETURN = 14'h0060;
	// lowest legal extended load address
	localparam logic [7:0] LOAD_EXT_MIN = 8'h20;
	// reset values
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic GIE_RST = 1'b0;
	// decoded operation kinds
	typedef enum logic [2:0] {
		OPK_NONE = 3'b000,
		OPK_STORE_DIRECT = 3'b001,
		OPK_STORE_EXT = 3'b010,
		OPK_LOAD_EXT = 3'b011,
		OPK_IRQ_RETURN = 3'b100,
		OPK_RET_LIT = 3'b101
	} mrx_opk_t;
	// sequencer states
	typedef enum logic [0:0] {
		ST_READY = 1'b0,
		ST_SECOND = 1'b1
	} mrx_state_t;
endpackage

// *** hw/mrx_stack_if.sv ***
// interface between the executor and its return stack
`timescale 1ns/100ps
interface mrx_stack_if #(
	parameter int PC_W = 11
);
	logic push; // one-cycle push request
	logic [PC_W-1:0] push_addr; // address saved by a push
	logic pop; // one-cycle pop request
	logic [PC_W-1:0] top; // current top entry
	modport owner (output push, output push_addr, output pop, input top);
	modport stack (input push, input push_addr, input pop, output top);
endinterface

// *** hw/mrx_stack.sv ***
// circular return stack for the executor
`timescale 1ns/100ps
module mrx_stack #(
	parameter int PC_W = 11,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	mrx_stack_if.stack st
);
	import mrx_pkg::*;
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	//------------------------------------------------------------
	// storage
	//------------------------------------------------------------
	logic [PC_W-1:0] mem_reg [DEPTH]; // saved return addresses
	logic [PTR_W-1:0] ptr_reg; // index of the top entry
	logic [PTR_W-1:0] ptr_up; // slot a push lands in

	// wraps silently: overflow overwrites the oldest entry, as small cores do
	assign ptr_up = (ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : ptr_reg + 1'b1;
	assign st.top = mem_reg[ptr_reg];

	// pointer: push moves up, pop moves back one entry
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			ptr_reg <= '0;
		end else if (st.push && !st.pop) begin
			ptr_reg <= ptr_up;
		end else if (st.pop && !st.push) begin
			// older saved address becomes the new top
			ptr_reg <= (ptr_reg == '0) ? PTR_W'(DEPTH - 1) : ptr_reg - 1'b1;
		end
	end

	// entries are written only on a push; no reset needed for data
	always_ff @(posedge clk_sys_in) begin
		if (st.push && !st.pop) begin
			mem_reg[ptr_up] <= st.push_addr;
		end else if (st.push && st.pop) begin
			// simultaneous push and pop replaces the top
			mem_reg[ptr_reg] <= st.push_addr;
		end
	end
endmodule // mrx_stack

// *** hw/mrx_exec.sv ***
// executor for accumulator moves and the two return instructions
`timescale 1ns/100ps
module mrx_exec #(
	parameter int PC_W = 11,
	parameter int STACK_DEPTH = 8
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic instr_valid_in, // instruction word offered
	input wire logic [mrx_pkg::OP_W-1:0] instr_in, // fetched opcode
	output logic ready_out, // high when an instruction may be taken
	input wire logic call_push_in, // core saves a return address
	input wire logic [PC_W-1:0] call_addr_in, // address to save
	input wire logic acc_load_in, // other units write the accumulator
	input wire logic [mrx_pkg::DATA_W-1:0] acc_data_in, // their value
	input wire logic irq_entry_in, // interrupt taken, clears enable
	input wire logic [mrx_pkg::DATA_W-1:0] file_rd_data_in, // read data for file_addr_out
	output logic file_wr_out, // one-cycle write strobe
	output logic file_rd_out, // one-cycle read strobe
	output logic file_ext_out, // access targets the extended space
	output logic [mrx_pkg::DATA_W-1:0] file_addr_out, // register address
	output logic [mrx_pkg::DATA_W-1:0] file_wr_data_out, // data written
	output logic bad_addr_out, // pulse: load below legal range ignored
	output logic [mrx_pkg::DATA_W-1:0] acc_out, // accumulator
	output logic global_irq_enable_out, // global interrupt enable
	output logic pc_load_out, // pulse: program counter reloaded
	output logic [PC_W-1:0] pc_out // new program counter value
);
	import mrx_pkg::*;

	//------------------------------------------------------------
	// decode
	//------------------------------------------------------------
	// classify an opcode; used for the taken word
	function automatic mrx_opk_t decode_op(input logic [OP_W-1:0] op);
		mrx_opk_t k;
		k = OPK_NONE;
		if (op == OPC_IRQ_RETURN) begin
			k = OPK_IRQ_RETURN;
		end else if (op[OP_W-1:OPC_STORE_DIRECT_POS] == OPC_STORE_DIRECT) begin
			k = OPK_STORE_DIRECT;
		end else if (op[OP_W-1:OPC_HI_POS] == OPC_STORE_EXT) begin
			k = OPK_STORE_EXT;
		end else if (op[OP_W-1:OPC_HI_POS] == OPC_LOAD_EXT) begin
			k = OPK_LOAD_EXT;
		end else if (op[OP_W-1:OPC_HI_POS] == OPC_RET_LIT) begin
			k = OPK_RET_LIT;
		end
		return k;
	endfunction

	mrx_opk_t opk; // kind of the offered instruction
	logic take; // instruction accepted this cycle
	logic [DATA_W-1:0] op_field; // low eight bits of the opcode
	mrx_state_t state_reg; // sequencer state
	mrx_state_t state_next;
	logic ld_pend_reg; // extended load waiting for read data
	logic [DATA_W-1:0] acc_reg;
	logic gie_reg;

	assign opk = decode_op(instr_in);
	assign take = instr_valid_in && (state_reg == ST_READY);
	assign op_field = instr_in[DATA_W-1:0];

	//------------------------------------------------------------
	// return stack
	//------------------------------------------------------------
	mrx_stack_if #(.PC_W(PC_W)) stk ();

	// only the two returns pop; pushes come from the core's call path
	assign stk.pop = take && ((opk == OPK_IRQ_RETURN) || (opk == OPK_RET_LIT));
	assign stk.push = call_push_in;
	assign stk.push_addr = call_addr_in;

	mrx_stack #(
		.PC_W(PC_W),
		.DEPTH(STACK_DEPTH)
	) u_stack (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.st(stk)
	);

	//------------------------------------------------------------
	// sequencer
	//------------------------------------------------------------
	// returns hold the core for one extra cycle
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_READY: begin
				if (take && (opk == OPK_IRQ_RETURN || opk == OPK_RET_LIT)) begin
					state_next = ST_SECOND;
				end
			end
			ST_SECOND: begin
				state_next = ST_READY;
			end
			default: begin
				state_next = ST_READY;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			state_reg <= ST_READY;
		end else begin
			state_reg <= state_next;
		end
	end

	// ready is registered so it leaves straight from a flip-flop
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			ready_out <= 1'b1;
		end else begin
			ready_out <= (state_next == ST_READY);
		end
	end

	//------------------------------------------------------------
	// register file access
	//------------------------------------------------------------
	// strobes and address for the cycle after the instruction is taken
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			file_wr_out <= 1'b0;
			file_rd_out <= 1'b0;
			file_ext_out <= 1'b0;
			file_addr_out <= 8'h00;
			file_wr_data_out <= 8'h00;
			bad_addr_out <= 1'b0;
			ld_pend_reg <= 1'b0;
		end else begin
			file_wr_out <= 1'b0;
			file_rd_out <= 1'b0;
			bad_addr_out <= 1'b0;
			ld_pend_reg <= 1'b0;
			if (take) begin
				case (opk)
					OPK_STORE_DIRECT: begin
						// seven-bit direct address, top bit zero
						file_wr_out <= 1'b1;
						file_ext_out <= 1'b0;
						file_addr_out <= {1'b0, op_field[6:0]};
						file_wr_data_out <= acc_reg;
					end
					OPK_STORE_EXT: begin
						file_wr_out <= 1'b1;
						file_ext_out <= 1'b1;
						file_addr_out <= op_field;
						file_wr_data_out <= acc_reg;
					end
					OPK_LOAD_EXT: begin
						// addresses below the legal floor are refused, accumulator kept
						if (op_field >= LOAD_EXT_MIN) begin
							file_rd_out <= 1'b1;
							file_ext_out <= 1'b1;
							file_addr_out <= op_field;
							ld_pend_reg <= 1'b1;
						end else begin
							bad_addr_out <= 1'b1;
						end
					end
					default: begin
						// returns and foreign opcodes touch no register
					end
				endcase
			end
		end
	end

	//------------------------------------------------------------
	// accumulator
	//------------------------------------------------------------
	// no status flag is produced here, so every move leaves flags alone
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			acc_reg <= ACC_RST;
		end else if (ld_pend_reg) begin
			// read data answers the strobe in the same cycle
			acc_reg <= file_rd_data_in;
		end else if (take && opk == OPK_RET_LIT) begin
			acc_reg <= op_field;
		end else if (acc_load_in) begin
			// outside writers lose to an instruction of this block
			acc_reg <= acc_data_in;
		end
	end
	assign acc_out = acc_reg;

	//------------------------------------------------------------
	// interrupt enable
	//------------------------------------------------------------
	// return re-enables; an entry in the same cycle wins so no event is lost
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			gie_reg <= GIE_RST;
		end else if (irq_entry_in) begin
			gie_reg <= 1'b0;
		end else if (take && opk == OPK_IRQ_RETURN) begin
			gie_reg <= 1'b1;
		end
	end
	assign global_irq_enable_out = gie_reg;

	//------------------------------------------------------------
	// program counter
	//------------------------------------------------------------
	// top entry is sampled before the pop takes effect
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			pc_load_out <= 1'b0;
			pc_out <= '0;
		end else begin
			pc_load_out <= 1'b0;
			if (stk.pop) begin
				pc_load_out <= 1'b1;
				pc_out <= stk.top;
			end
		end
	end
endmodule // mrx_exec

// *** tb/mrx_regfile_model.sv ***
// behavioural data register file facing the executor
`timescale 1ns/100ps
module mrx_regfile_model (
	input wire logic clk_sys_in,
	input wire logic file_wr_in,
	input wire logic file_rd_in,
	input wire logic file_ext_in,
	input wire logic [7:0] file_addr_in,
	input wire logic [7:0] file_wr_data_in,
	output logic [7:0] file_rd_data_out
);
	logic [7:0] mem [0:511]; // direct space below, extended space above
	logic [7:0] junk_reg = 8'h5A; // changes every cycle outside reads
	// write on the strobe, scramble the idle pattern
	always @(posedge clk_sys_in) begin
		if (file_wr_in) begin
			mem[{file_ext_in, file_addr_in}] <= file_wr_data_in;
		end
		junk_reg <= ~junk_reg + 8'h01;
	end
	// data only while the read strobe stands, so a late sample cannot pass
	assign file_rd_data_out = file_rd_in ? mem[{file_ext_in, file_addr_in}] : junk_reg;
endmodule // mrx_regfile_model

// *** tb/mrx_exec_monitor.sv ***
// port checker for the move and return executor
`timescale 1ns/100ps
module mrx_exec_monitor (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic instr_valid_in,
	input wire logic [13:0] instr_in,
	input wire logic ready_out,
	input wire logic irq_entry_in,
	input wire logic [7:0] file_rd_data_in,
	input wire logic file_wr_out,
	input wire logic file_rd_out,
	input wire logic file_ext_out,
	input wire logic [7:0] file_addr_out,
	input wire logic [7:0] file_wr_data_out,
	input wire logic bad_addr_out,
	input wire logic [7:0] acc_out,
	input wire logic global_irq_enable_out,
	input wire logic pc_load_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	logic take; // instruction accepted at this edge
	assign take = instr_valid_in && ready_out;
	//------------------------------------------------------------
	// properties
	//------------------------------------------------------------
	property p_store_direct;
		take && instr_in[13:7] == 7'h01 |=> file_wr_out && !file_ext_out
			&& file_addr_out == {1'b0, $past(instr_in[6:0])} && file_wr_data_out == $past(acc_out);
	endproperty
	a_store_direct: assert property (p_store_direct) else $error("direct store wrong");
	property p_store_ext;
		take && instr_in[13:8] == 6'h1E |=> file_wr_out && file_ext_out
			&& file_addr_out == $past(instr_in[7:0]) && file_wr_data_out == $past(acc_out);
	endproperty
	a_store_ext: assert property (p_store_ext) else $error("extended store wrong");
	property p_load_ext;
		take && instr_in[13:8] == 6'h1F && instr_in[7:0] >= 8'h20 |=> file_rd_out ##1 acc_out == $past(file_rd_data_in);
	endproperty
	a_load_ext: assert property (p_load_ext) else $error("extended load wrong");
	property p_load_low;
		take && instr_in[13:8] == 6'h1F && instr_in[7:0] < 8'h20 |=> bad_addr_out && !file_rd_out;
	endproperty
	a_load_low: assert property (p_load_low) else $error("low load not refused");
	property p_irq_ret;
		take && instr_in == 14'h0060 |=> pc_load_out && !ready_out ##1 ready_out;
	endproperty
	a_irq_ret: assert property (p_irq_ret) else $error("interrupt return timing wrong");
	property p_irq_enable;
		take && instr_in == 14'h0060 && !irq_entry_in |=> $rose(global_irq_enable_out) || $stable(global_irq_enable_out) && global_irq_enable_out;
	endproperty
	a_irq_enable: assert property (p_irq_enable) else $error("enable not set");
	property p_ret_lit;
		take && instr_in[13:8] == 6'h18 |=> pc_load_out && !ready_out && acc_out == $past(instr_in[7:0]);
	endproperty
	a_ret_lit: assert property (p_ret_lit) else $error("literal return wrong");
endmodule // mrx_exec_monitor
bind mrx_exec mrx_exec_monitor u_mon (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .instr_valid_in(instr_valid_in),
	.instr_in(instr_in), .ready_out(ready_out), .irq_entry_in(irq_entry_in), .file_rd_data_in(file_rd_data_in),
	.file_wr_out(file_wr_out), .file_rd_out(file_rd_out), .file_ext_out(file_ext_out), .file_addr_out(file_addr_out),
	.file_wr_data_out(file_wr_data_out), .bad_addr_out(bad_addr_out), .acc_out(acc_out),
	.global_irq_enable_out(global_irq_enable_out), .pc_load_out(pc_load_out));

// *** tb/tb_top.sv ***
// self-checking bench for the move and return executor
`timescale 1ns/100ps
module tb_top;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic instr_valid_in = 1'b0;
	logic [13:0] instr_in = 14'h0000;
	logic call_push_in = 1'b0;
	logic [10:0] call_addr_in = 11'h000;
	logic acc_load_in = 1'b0;
	logic [7:0] acc_data_in = 8'h00;
	logic irq_entry_in = 1'b0;
	logic [7:0] file_rd_data_in;
	logic ready_out, file_wr_out, file_rd_out, file_ext_out, bad_addr_out, global_irq_enable_out, pc_load_out;
	logic [7:0] file_addr_out, file_wr_data_out, acc_out;
	logic [10:0] pc_out;
	int err_total = 0;
	int comparisons = 0;
	always #2.5 clk_sys_in = ~clk_sys_in;
	mrx_exec #(.PC_W(11), .STACK_DEPTH(8)) dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.instr_valid_in(instr_valid_in), .instr_in(instr_in), .ready_out(ready_out), .call_push_in(call_push_in),
		.call_addr_in(call_addr_in), .acc_load_in(acc_load_in), .acc_data_in(acc_data_in), .irq_entry_in(irq_entry_in),
		.file_rd_data_in(file_rd_data_in), .file_wr_out(file_wr_out), .file_rd_out(file_rd_out),
		.file_ext_out(file_ext_out), .file_addr_out(file_addr_out), .file_wr_data_out(file_wr_data_out),
		.bad_addr_out(bad_addr_out), .acc_out(acc_out), .global_irq_enable_out(global_irq_enable_out),
		.pc_load_out(pc_load_out), .pc_out(pc_out));
	mrx_regfile_model u_regs (.clk_sys_in(clk_sys_in), .file_wr_in(file_wr_out), .file_rd_in(file_rd_out),
		.file_ext_in(file_ext_out), .file_addr_in(file_addr_out), .file_wr_data_in(file_wr_data_out),
		.file_rd_data_out(file_rd_data_in));
	//------------------------------------------------------------
	// shared tasks
	//------------------------------------------------------------
	task automatic report_and_stop;
		$display("comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one-cycle side pulses: push, accumulator write, interrupt entry
	task automatic side(input logic p, input logic a, input logic i, input logic [10:0] v);
		@(posedge clk_sys_in);
		call_push_in <= p;
		acc_load_in <= a;
		irq_entry_in <= i;
		call_addr_in <= v;
		acc_data_in <= v[7:0];
		@(posedge clk_sys_in);
		call_push_in <= 1'b0;
		acc_load_in <= 1'b0;
		irq_entry_in <= 1'b0;
		@(negedge clk_sys_in);
	endtask
	// offer one opcode once ready, return at the negedge of the answer cycle
	task automatic issue(input logic [13:0] op);
		int n;
		n = 0;
		@(negedge clk_sys_in);
		while (ready_out !== 1'b1) begin
			n++;
			if (n > 8) begin
				err_total++;
				report_and_stop();
			end
			@(negedge clk_sys_in);
		end
		@(posedge clk_sys_in);
		instr_valid_in <= 1'b1;
		instr_in <= op;
		@(posedge clk_sys_in);
		instr_valid_in <= 1'b0;
		@(negedge clk_sys_in);
	endtask
	//------------------------------------------------------------
	// scenarios
	//------------------------------------------------------------
	task automatic t_stores;
		side(1'b0, 1'b1, 1'b0, 11'h04F);
		issue(14'h00FF);
		chk({6'h00, file_wr_out, file_ext_out, file_addr_out}, 16'h027F);
		chk(file_wr_data_out, 16'h004F);
		issue(14'h1EFF);
		chk({6'h00, file_wr_out, file_ext_out, file_addr_out}, 16'h03FF);
		chk(file_wr_data_out, 16'h004F);
		$display("test stores done");
	endtask
	task automatic t_load;
		side(1'b0, 1'b1, 1'b0, 11'h03C);
		issue(14'h1E20);
		side(1'b0, 1'b1, 1'b0, 11'h000);
		issue(14'h1F20);
		chk({6'h00, file_rd_out, file_ext_out, file_addr_out}, 16'h0320);
		@(negedge clk_sys_in);
		chk(acc_out, 16'h003C);
		issue(14'h1F1F);
		chk({bad_addr_out, file_rd_out}, 16'h0002);
		$display("test load done");
	endtask
	task automatic t_returns;
		side(1'b1, 1'b0, 1'b0, 11'h123);
		side(1'b1, 1'b0, 1'b0, 11'h456);
		side(1'b1, 1'b0, 1'b1, 11'h7FF);
		chk(global_irq_enable_out, 16'h0000);
		issue(14'h0060);
		chk({pc_load_out, ready_out, global_irq_enable_out, 1'b0, pc_out}, 16'h57FF);
		@(negedge clk_sys_in);
		chk(ready_out, 16'h0001);
		// enable is now set, so an interrupt entry must visibly clear it
		side(1'b0, 1'b0, 1'b1, 11'h000);
		chk(global_irq_enable_out, 16'h0000);
		issue(14'h18A5);
		chk({pc_load_out, ready_out, 3'h0, pc_out}, 16'h8456);
		chk(acc_out, 16'h00A5);
		issue(14'h1800);
		chk({pc_load_out, acc_out, pc_out[6:0]}, 16'h8023);
		chk(pc_out, 16'h0123);
		$display("test returns done");
	endtask
	initial begin
		repeat (16) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		@(negedge clk_sys_in);
		chk({ready_out, global_irq_enable_out, acc_out}, 16'h0200);
		t_stores();
		t_load();
		t_returns();
		report_and_stop();
	end
endmodule // tb_top
